// ### hw/adc_port_pkg.sv
package adc_port_pkg;

	// Serial frame layout
	localparam int COMM_W       = 8;
	localparam int DATA_W       = 24;
	localparam int ADDR_W       = 6;
	localparam int COMM_WEN_BIT = 7;
	localparam int COMM_RD_BIT  = 6;

	// Register slots
	localparam logic [5:0]  CONV_CTRL_ADDR = 6'h01;
	localparam logic [5:0]  DATA_ADDR      = 6'h04;
	localparam int          REG_COUNT      = 8;
	localparam int          CLK_SEL_LSB    = 2;
	localparam logic [23:0] CONV_CTRL_RST  = 24'h000000;

	// Device clock-domain counts
	localparam int OSC_HALF_CYC      = 4;
	localparam int CONV_MCLK_TICKS   = 64;
	localparam int READY_GUARD_TICKS = 4;

	// Host serial clock timing
	localparam int CLK_SYS_NS    = 5;
	localparam int SCLK_HALF_NS  = 25;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int SETTLE_CYC    = 3;

	typedef enum logic [1:0]
	{
		CLK_INT     = 2'b00,
		CLK_INT_OUT = 2'b01,
		CLK_EXT     = 2'b10,
		CLK_XTAL    = 2'b11
	} clk_src_type;

	typedef enum logic [0:0]
	{
		PH_COMM = 1'b0,
		PH_DATA = 1'b1
	} phase_type;

	typedef enum logic [1:0]
	{
		H_IDLE  = 2'b00,
		H_SETUP = 2'b01,
		H_SHIFT = 2'b10,
		H_END   = 2'b11
	} host_state_type;

endpackage

// ### hw/adc_link_if.sv
`timescale 1ns/100ps
interface adc_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout_o;
	logic dout_oe;
	wire  dout_line;

	// Released line shows the pull-up level, so idle reads high
	assign dout_line = dout_oe ? dout_o : 1'b1;

	modport dev
	(
		input  sclk,
		input  cs_n,
		input  din,
		output dout_o,
		output dout_oe
	);

	modport host
	(
		output sclk,
		output cs_n,
		output din,
		input  dout_line
	);
endinterface

// ### hw/adc_port_device.sv
`timescale 1ns/100ps
module adc_port_device
#(
	parameter int DATA_W     = adc_port_pkg::DATA_W,
	parameter int NREG       = adc_port_pkg::REG_COUNT,
	parameter int CONV_TICKS = adc_port_pkg::CONV_MCLK_TICKS,
	parameter int GUARD      = adc_port_pkg::READY_GUARD_TICKS,
	parameter int OSC_HALF   = adc_port_pkg::OSC_HALF_CYC
)
(
	// System clock and control
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic                 ce,
	// Serial link
	adc_link_if.dev                   link,
	// Converter side
	input  wire logic [DATA_W-1:0]    sample_data,
	output logic                      data_ready_n,
	output logic                      mclk_tick,
	output adc_port_pkg::clk_src_type clock_source_select,
	// Clock pin
	input  wire logic                 crystal_or_clock_pin_in,
	output logic                      crystal_or_clock_pin_out,
	output logic                      crystal_or_clock_pin_oe
);
	import adc_port_pkg::*;

	localparam int IDX_W = $clog2(NREG);
	localparam int CNT_W = $clog2(DATA_W) + 1;
	localparam int CONV_W = $clog2(CONV_TICKS);
	localparam int OSC_W = $clog2(OSC_HALF) + 1;

	// Link-domain state
	logic                frame_rst;
	phase_type           phase_q;
	logic [CNT_W-1:0]    bit_cnt_q;
	logic [DATA_W-1:0]   in_sr_q;
	logic [DATA_W-1:0]   out_sr_q;
	logic                rd_q;
	logic [ADDR_W-1:0]   addr_q;
	logic [COMM_W-1:0]   comm_word;
	logic [DATA_W-1:0]   data_word;
	logic                comm_done;
	logic                data_done;
	logic                drive_q;
	logic                bit_q;
	logic                wr_tgl_q;
	logic                rd_tgl_q;
	logic [ADDR_W-1:0]   wr_addr_q;
	logic [DATA_W-1:0]   wr_data_q;

	// System-domain state
	logic [DATA_W-1:0]   regs_q [NREG];
	logic [DATA_W-1:0]   result_q;
	logic                ready_n_q;
	logic [1:0]          wr_sync_q;
	logic                wr_seen_q;
	logic [1:0]          rd_sync_q;
	logic                rd_seen_q;
	logic                wr_event;
	logic                rd_event;
	logic [OSC_W-1:0]    osc_cnt_q;
	logic                osc_q;
	logic                osc_tick;
	logic [1:0]          pin_sync_q;
	logic                pin_prev_q;
	logic                pin_tick;
	logic                mclk_tick_q;
	logic                clk_oe_q;
	logic [CONV_W-1:0]   conv_cnt_q;
	logic                update;
	logic                guard_hit;
	clk_src_type         clk_sel;

	function automatic logic [DATA_W-1:0] read_word(
		input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] w;
		w = '0;
		if (a == DATA_ADDR)
			w = result_q;
		else if (a < ADDR_W'(NREG))
			w = regs_q[a[IDX_W-1:0]];
		return w;
	endfunction

	// Chip select high aborts any frame; tied low, frames run by count
	assign frame_rst = link.cs_n | srst;
	assign comm_word = {in_sr_q[COMM_W-2:0], link.din};
	assign data_word = {in_sr_q[DATA_W-2:0], link.din};
	assign comm_done = (phase_q == PH_COMM)
		&& (bit_cnt_q == CNT_W'(COMM_W - 1));
	assign data_done = (phase_q == PH_DATA)
		&& (bit_cnt_q == CNT_W'(DATA_W - 1));

	always_ff @(posedge link.sclk or posedge frame_rst)
	begin
		if (frame_rst)
			in_sr_q <= '0;
		else
			in_sr_q <= data_word;
	end

	// A command byte with the enable bit set is dropped, so a high
	// input line lets the host resynchronise the port.
	always_ff @(posedge link.sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			phase_q   <= PH_COMM;
			bit_cnt_q <= '0;
		end
		else
		begin
			unique case (phase_q)
				PH_COMM:
				begin
					if (comm_done)
					begin
						bit_cnt_q <= '0;
						if (!comm_word[COMM_WEN_BIT])
							phase_q <= PH_DATA;
					end
					else
						bit_cnt_q <= bit_cnt_q + CNT_W'(1);
				end
				PH_DATA:
				begin
					if (data_done)
					begin
						bit_cnt_q <= '0;
						phase_q   <= PH_COMM;
					end
					else
						bit_cnt_q <= bit_cnt_q + CNT_W'(1);
				end
			endcase
		end
	end

	always_ff @(posedge link.sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			rd_q     <= 1'b0;
			addr_q   <= '0;
			out_sr_q <= '0;
		end
		else if (comm_done)
		begin
			rd_q     <= comm_word[COMM_RD_BIT];
			addr_q   <= comm_word[ADDR_W-1:0];
			out_sr_q <= read_word(comm_word[ADDR_W-1:0]);
		end
		else if (phase_q == PH_DATA)
			out_sr_q <= {out_sr_q[DATA_W-2:0], 1'b0};
	end

	// Kept outside the frame reset so a deselect cannot fake an event
	always_ff @(posedge link.sclk or posedge srst)
	begin
		if (srst)
		begin
			wr_tgl_q  <= 1'b0;
			rd_tgl_q  <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end
		else if (data_done && !link.cs_n)
		begin
			if (!rd_q)
			begin
				wr_addr_q <= addr_q;
				wr_data_q <= data_word;
				wr_tgl_q  <= ~wr_tgl_q;
			end
			else if (addr_q == DATA_ADDR)
				rd_tgl_q <= ~rd_tgl_q;
		end
	end

	always_ff @(negedge link.sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			drive_q <= 1'b0;
			bit_q   <= 1'b0;
		end
		else
		begin
			drive_q <= (phase_q == PH_DATA) && rd_q;
			bit_q   <= out_sr_q[DATA_W-1];
		end
	end

	// Pin mux is combinational: data and ready live in two domains
	assign link.dout_oe = ~link.cs_n;
	// Ready returns right after the last rise: with select tied low
	// no further falling edge comes to clear drive_q
	assign link.dout_o  = (drive_q && phase_q == PH_DATA) ?
		bit_q : ready_n_q;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wr_sync_q <= '0;
			wr_seen_q <= 1'b0;
			rd_sync_q <= '0;
			rd_seen_q <= 1'b0;
		end
		else if (ce)
		begin
			wr_sync_q <= {wr_sync_q[0], wr_tgl_q};
			wr_seen_q <= wr_sync_q[1];
			rd_sync_q <= {rd_sync_q[0], rd_tgl_q};
			rd_seen_q <= rd_sync_q[1];
		end
	end

	assign wr_event = wr_sync_q[1] ^ wr_seen_q;
	assign rd_event = rd_sync_q[1] ^ rd_seen_q;

	// The data slot is read-only; its storage is result_q
	for (genvar i = 0; i < NREG; i++)
	begin : g_reg
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				regs_q[i] <= (i == int'(CONV_CTRL_ADDR)) ?
					CONV_CTRL_RST : '0;
			else if (ce && wr_event && wr_addr_q == ADDR_W'(i)
				&& wr_addr_q != DATA_ADDR)
				regs_q[i] <= wr_data_q;
		end
	end

	assign clk_sel = clk_src_type'(regs_q[CONV_CTRL_ADDR[IDX_W-1:0]]
		[CLK_SEL_LSB +: 2]);
	assign clock_source_select = clk_sel;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			osc_cnt_q <= '0;
			osc_q     <= 1'b0;
		end
		else if (ce)
		begin
			if (osc_cnt_q == OSC_W'(OSC_HALF - 1))
			begin
				osc_cnt_q <= '0;
				osc_q     <= ~osc_q;
			end
			else
				osc_cnt_q <= osc_cnt_q + OSC_W'(1);
		end
	end

	assign osc_tick = (osc_cnt_q == OSC_W'(OSC_HALF - 1)) && !osc_q;
	assign pin_tick = pin_sync_q[1] && !pin_prev_q;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pin_sync_q  <= '0;
			pin_prev_q  <= 1'b0;
			mclk_tick_q <= 1'b0;
			clk_oe_q    <= 1'b0;
		end
		else if (ce)
		begin
			pin_sync_q <= {pin_sync_q[0], crystal_or_clock_pin_in};
			pin_prev_q <= pin_sync_q[1];
			unique case (clk_sel)
				CLK_INT, CLK_INT_OUT: mclk_tick_q <= osc_tick;
				CLK_EXT, CLK_XTAL:    mclk_tick_q <= pin_tick;
			endcase
			clk_oe_q <= (clk_sel == CLK_INT_OUT);
		end
	end

	assign crystal_or_clock_pin_out = osc_q;
	assign crystal_or_clock_pin_oe  = clk_oe_q;
	assign mclk_tick                = mclk_tick_q;

	assign update = mclk_tick_q
		&& conv_cnt_q == CONV_W'(CONV_TICKS - 1);
	assign guard_hit = mclk_tick_q
		&& conv_cnt_q == CONV_W'(CONV_TICKS - 1 - GUARD);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			conv_cnt_q <= '0;
			result_q   <= '0;
		end
		else if (ce && mclk_tick_q)
		begin
			if (update)
			begin
				conv_cnt_q <= '0;
				result_q   <= sample_data;
			end
			else
				conv_cnt_q <= conv_cnt_q + CONV_W'(1);
		end
	end

	// A fresh result beats a clear arriving in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			ready_n_q <= 1'b1;
		else if (ce)
		begin
			if (update)
				ready_n_q <= 1'b0;
			else if (rd_event)
				ready_n_q <= 1'b1;
			else if (guard_hit)
				ready_n_q <= 1'b1;
		end
	end

	assign data_ready_n = ready_n_q;
endmodule

// ### hw/adc_port_host.sv
`timescale 1ns/100ps
module adc_port_host
#(
	parameter int DATA_W    = adc_port_pkg::DATA_W,
	parameter int HALF_CYC  = adc_port_pkg::SCLK_HALF_CYC
)
(
	// System clock and control
	input  wire logic                           clk_sys,
	input  wire logic                           srst,
	input  wire logic                           ce,
	// Serial link
	adc_link_if.host                            link,
	// Command request
	input  wire logic                           cmd_valid,
	output logic                                cmd_ready,
	input  wire logic                           cmd_read,
	input  wire logic [adc_port_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0]              cmd_wdata,
	// Read answer
	output logic                                rsp_valid,
	output logic [DATA_W-1:0]                   rsp_data,
	// Ready watch
	input  wire logic                           hold_select,
	output logic                                ready_event
);
	import adc_port_pkg::*;

	localparam int FRAME_W = COMM_W + DATA_W;
	localparam int FCNT_W  = $clog2(FRAME_W) + 1;
	localparam int HCNT_W  = $clog2(HALF_CYC) + 1;
	localparam int SCNT_W  = $clog2(SETTLE_CYC) + 1;

	host_state_type     state_q;
	logic [HCNT_W-1:0]  half_cnt_q;
	logic [FCNT_W-1:0]  bit_cnt_q;
	logic [FRAME_W-1:0] tx_q;
	logic [DATA_W-1:0]  rx_q;
	logic               read_q;
	logic               sclk_q;
	logic               cs_n_q;
	logic               din_q;
	logic               cmd_ready_q;
	logic               rsp_valid_q;
	logic [DATA_W-1:0]  rsp_data_q;
	logic [1:0]         dsync_q;
	logic               dprev_q;
	logic [SCNT_W-1:0]  settle_q;
	logic               ready_event_q;
	logic               half_end;

	assign half_end = (half_cnt_q == HCNT_W'(HALF_CYC - 1));

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			half_cnt_q <= '0;
		else if (ce)
		begin
			if (state_q == H_IDLE || half_end)
				half_cnt_q <= '0;
			else
				half_cnt_q <= half_cnt_q + HCNT_W'(1);
		end
	end

	// Idle clock high; bits change on the falling edge we make, and
	// the device samples them on the rising edge half a period later.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_q     <= H_IDLE;
			bit_cnt_q   <= '0;
			tx_q        <= '0;
			rx_q        <= '0;
			read_q      <= 1'b0;
			sclk_q      <= 1'b1;
			cs_n_q      <= 1'b1;
			din_q       <= 1'b1;
			cmd_ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= '0;
		end
		else if (ce)
		begin
			rsp_valid_q <= 1'b0;
			unique case (state_q)
				H_IDLE:
				begin
					cmd_ready_q <= 1'b1;
					cs_n_q      <= ~hold_select;
					if (cmd_valid && cmd_ready_q)
					begin
						cmd_ready_q <= 1'b0;
						cs_n_q      <= 1'b0;
						read_q      <= cmd_read;
						tx_q        <= {1'b0, cmd_read, cmd_addr,
							cmd_read ? {DATA_W{1'b1}} : cmd_wdata};
						bit_cnt_q   <= '0;
						state_q     <= H_SETUP;
					end
				end
				H_SETUP:
				begin
					if (half_end)
					begin
						sclk_q  <= 1'b0;
						din_q   <= tx_q[FRAME_W-1];
						tx_q    <= {tx_q[FRAME_W-2:0], 1'b1};
						state_q <= H_SHIFT;
					end
				end
				H_SHIFT:
				begin
					if (half_end && !sclk_q)
					begin
						sclk_q    <= 1'b1;
						rx_q      <= {rx_q[DATA_W-2:0], dsync_q[1]};
						bit_cnt_q <= bit_cnt_q + FCNT_W'(1);
					end
					else if (half_end)
					begin
						if (bit_cnt_q == FCNT_W'(FRAME_W))
							state_q <= H_END;
						else
						begin
							sclk_q <= 1'b0;
							din_q  <= tx_q[FRAME_W-1];
							tx_q   <= {tx_q[FRAME_W-2:0], 1'b1};
						end
					end
				end
				H_END:
				begin
					if (half_end)
					begin
						cs_n_q      <= ~hold_select;
						din_q       <= 1'b1;
						rsp_valid_q <= read_q;
						rsp_data_q  <= rx_q;
						state_q     <= H_IDLE;
					end
				end
			endcase
		end
	end

	// The line needs a few cycles to settle after a frame or a select
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			dsync_q       <= 2'b11;
			dprev_q       <= 1'b1;
			settle_q      <= '0;
			ready_event_q <= 1'b0;
		end
		else if (ce)
		begin
			dsync_q <= {dsync_q[0], link.dout_line};
			dprev_q <= dsync_q[1];
			if (state_q != H_IDLE || cs_n_q)
				settle_q <= '0;
			else if (settle_q != SCNT_W'(SETTLE_CYC))
				settle_q <= settle_q + SCNT_W'(1);
			ready_event_q <= (settle_q == SCNT_W'(SETTLE_CYC))
				&& state_q == H_IDLE && dprev_q && !dsync_q[1];
		end
	end

	assign link.sclk   = sclk_q;
	assign link.cs_n   = cs_n_q;
	assign link.din    = din_q;
	assign cmd_ready   = cmd_ready_q;
	assign rsp_valid   = rsp_valid_q;
	assign rsp_data    = rsp_data_q;
	assign ready_event = ready_event_q;
endmodule

// ### tb/adc_link_chk.sv
`timescale 1ns/100ps
module adc_link_chk
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Link lines
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout_o,
	input wire logic dout_oe
);
	logic       sclk_q;
	logic [4:0] rise_cnt_q;
	logic       rd_q;
	logic       rise;

	assign rise = sclk && !sclk_q;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			sclk_q <= 1'h1;
		else
			sclk_q <= sclk;
	end

	// Wraps at 32 so frames stay delimited when select is held low
	always_ff @(posedge clk_sys)
	begin
		if (srst || cs_n)
			rise_cnt_q <= 5'h00;
		else if (rise)
			rise_cnt_q <= rise_cnt_q + 5'h01;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			rd_q <= 1'h0;
		else if (rise && rise_cnt_q == 5'h01)
			rd_q <= din;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence first_bit_s;
		$fell(sclk) ##[1:8] $rose(sclk);
	endsequence

	sequence data_phase_s;
		!cs_n && rd_q && rise_cnt_q >= 5'h08 && rise_cnt_q != 5'h1F;
	endsequence

	release_on_cs_a: assert property (dout_oe == !cs_n)
		else $error("dout enable does not follow select");
	first_clock_a: assert property ($fell(cs_n) |-> ##[1:8] first_bit_s)
		else $error("no serial clock after select");
	clock_selected_a: assert property ($changed(sclk) |-> !cs_n)
		else $error("serial clock moved while deselected");
	din_setup_hold_a: assert property
		($rose(sclk) |-> $stable(din) ##1 $stable(din))
		else $error("serial input moved around rising edge");
	frame_whole_a: assert property
		($rose(cs_n) |-> sclk && rise_cnt_q == 5'h00)
		else $error("frame ended off a word boundary");
	write_enable_a: assert property
		((rise && rise_cnt_q == 5'h00 && !cs_n) |-> !din)
		else $error("command enable bit not zero");
	out_stable_rise_a: assert property
		((data_phase_s ##0 $rose(sclk)) |-> $stable(dout_o))
		else $error("output bit moved before rising edge");
	out_moves_low_a: assert property
		((data_phase_s ##0 (rise_cnt_q != 5'h08 && $changed(dout_o)))
			|-> !sclk)
		else $error("output bit moved while clock high");

	cover property (data_phase_s ##0 $rose(sclk));
endmodule

// ### tb/test_adc_serial_port_and_clock_select.sv
`timescale 1ns/100ps
module test_adc_serial_port_and_clock_select;
	import adc_port_pkg::*;

	localparam int XCYC = 120;

	logic        clk_sys;
	logic        xclk;
	real         xhalf = 7.5;
	logic        srst = 1'h1;
	logic        ce = 1'h1;
	logic [23:0] sample_data = 24'h000000;
	logic        data_ready_n;
	logic        mclk_tick;
	clk_src_type clock_source_select;
	logic        pin_in;
	logic        pin_out;
	logic        pin_oe;
	logic        cmd_valid = 1'h0;
	logic        cmd_ready;
	logic        cmd_read = 1'h0;
	logic [5:0]  cmd_addr = 6'h00;
	logic [23:0] cmd_wdata = 24'h000000;
	logic        rsp_valid;
	logic [23:0] rsp_data;
	logic        hold_select = 1'h0;
	logic        ready_event;
	int          miscompares = 0;
	int          comparisons = 0;
	int          events = 0;
	int          ev0;
	int          n;
	logic [23:0] w;
	logic [23:0] exp_q[$];

	adc_link_if lnk();

	// Clock pin resolved from both drivers
	assign pin_in = pin_oe ? pin_out : xclk;

	adc_port_device #(.CONV_TICKS(8), .GUARD(2)) u_adc_port_device
	(
		.clk_sys                 (clk_sys),
		.srst                    (srst),
		.ce                      (ce),
		.link                    (lnk.dev),
		.sample_data             (sample_data),
		.data_ready_n            (data_ready_n),
		.mclk_tick               (mclk_tick),
		.clock_source_select     (clock_source_select),
		.crystal_or_clock_pin_in (pin_in),
		.crystal_or_clock_pin_out(pin_out),
		.crystal_or_clock_pin_oe (pin_oe)
	);

	adc_port_host u_adc_port_host
	(
		.clk_sys    (clk_sys),
		.srst       (srst),
		.ce         (ce),
		.link       (lnk.host),
		.cmd_valid  (cmd_valid),
		.cmd_ready  (cmd_ready),
		.cmd_read   (cmd_read),
		.cmd_addr   (cmd_addr),
		.cmd_wdata  (cmd_wdata),
		.rsp_valid  (rsp_valid),
		.rsp_data   (rsp_data),
		.hold_select(hold_select),
		.ready_event(ready_event)
	);

	adc_link_chk u_adc_link_chk
	(
		.clk_sys(clk_sys),
		.srst   (srst),
		.sclk   (lnk.sclk),
		.cs_n   (lnk.cs_n),
		.din    (lnk.din),
		.dout_o (lnk.dout_o),
		.dout_oe(lnk.dout_oe)
	);

	initial
	begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial
	begin
		xclk = 1'h0;
		forever #xhalf xclk = ~xclk;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Leaves n holding the cycles waited
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
			if (n > lim)
			begin
				miscompares++;
				$display("[FAIL] %0t wait ran out", $time);
				report_and_stop();
			end
		end
		while (s !== v);
	endtask

	task automatic xfer(input logic rd, input logic [5:0] a,
		input logic [23:0] d);
		wait_lvl(cmd_ready, 1'h1, 3000);
		cmd_valid = 1'h1;
		cmd_read = rd;
		cmd_addr = a;
		cmd_wdata = rd ? 24'(~d) : d;
		if (rd)
			exp_q.push_back(d);
		@(negedge clk_sys);
		cmd_valid = 1'h0;
		wait_lvl(cmd_ready, 1'h1, 3000);
	endtask

	always @(posedge clk_sys)
	begin
		if (rsp_valid === 1'h1)
			check(rsp_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
		if (ready_event === 1'h1)
			events++;
	end

	initial
	begin
		void'($urandom(12));
		repeat (16) @(negedge clk_sys);
		srst = 1'h0;
		check(data_ready_n, 1'h1);
		check(clock_source_select, CLK_INT);
		check(pin_oe, 1'h0);
		check(lnk.dout_oe, 1'h0);
		xfer(1'h1, CONV_CTRL_ADDR, CONV_CTRL_RST);
		$display("test reset done");

		// Every source, ending on the internal one
		for (int i = 0; i < 4; i++)
		begin
			w = $urandom();
			w[3:2] = 2'(3 - i);
			xfer(1'h0, CONV_CTRL_ADDR, w);
			repeat (8) @(negedge clk_sys);
			check(clock_source_select, w[3:2]);
			check(pin_oe, w[3:2] == 2'h1);
			wait_lvl(mclk_tick, 1'h1, 400);
			xfer(1'h1, CONV_CTRL_ADDR, w);
		end
		$display("test clock sources done");

		// Slot 9 must not alias onto slot 1
		xfer(1'h0, DATA_ADDR, 24'hA5A5A5);
		xfer(1'h0, 6'h09, 24'h5A5A5A);
		xfer(1'h1, 6'h09, 24'h000000);
		xfer(1'h1, DATA_ADDR, 24'h000000);
		xfer(1'h1, CONV_CTRL_ADDR, w);
		$display("test refused writes done");

		// Slow external clock so a read fits between updates
		xhalf = 300.0;
		w[3:2] = 2'h2;
		sample_data = $urandom();
		hold_select = 1'h1;
		xfer(1'h0, CONV_CTRL_ADDR, w);
		wait_lvl(data_ready_n, 1'h1, 3000);
		wait_lvl(data_ready_n, 1'h0, 3000);
		ev0 = events;
		for (n = 0; n < 20 && events == ev0; n++)
			@(negedge clk_sys);
		check(lnk.dout_line, 1'h0);
		check(events - ev0, 1);
		xfer(1'h1, DATA_ADDR, sample_data);
		check(data_ready_n, 1'h1);
		check(lnk.dout_line, 1'h1);
		$display("test three wire read done");

		wait_lvl(data_ready_n, 1'h0, 3000);
		wait_lvl(data_ready_n, 1'h1, 3000);
		wait_lvl(data_ready_n, 1'h0, 3000);
		check(n > 2 * XCYC - 10 && n < 2 * XCYC + 10, 1'h1);
		hold_select = 1'h0;
		xfer(1'h1, CONV_CTRL_ADDR, w);
		$display("test unread result done");
		report_and_stop();
	end
endmodule
